// *** pkg/scan_tap_pkg.sv ***
// constants for the boundary-scan test access logic
package scan_tap_pkg;
   // ----------------------------------------------------------------------
   // register sizes
   // ----------------------------------------------------------------------
   localparam int unsigned IR_WIDTH  = 2;
   localparam int unsigned BSR_CELLS = 84;

   // ----------------------------------------------------------------------
   // instruction codes
   // ----------------------------------------------------------------------
   localparam logic [IR_WIDTH-1:0] INSTR_EXTEST       = 2'h0;
   localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE       = 2'h1;
   localparam logic [IR_WIDTH-1:0] INSTR_BYPASS_TEST  = 2'h2;
   localparam logic [IR_WIDTH-1:0] bypass_functional  = 2'h3;
   localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE   = 2'h1;

   // ----------------------------------------------------------------------
   // enable cell positions
   // ----------------------------------------------------------------------
   localparam int unsigned CELL_OE_OUTBOUND    = 32;
   localparam int unsigned CELL_OE_INBOUND     = 41;
   localparam int unsigned CELL_OE_CLOCK_IN    = 46;
   localparam int unsigned CELL_OE_OUTPUT_ONLY = 52;
   localparam int unsigned CELL_OE_DATA        = 71;

   // ----------------------------------------------------------------------
   // tap controller states
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_TEST_LOGIC_RESET,
      ST_RUN_IDLE,
      ST_SELECT_DR,
      ST_CAPTURE_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPDATE_DR,
      ST_SELECT_IR,
      ST_CAPTURE_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPDATE_IR
   } tap_state_e;
endpackage

// *** rtl/pin_sync.sv ***
// two-flop synchroniser for pin levels entering the reference clock domain
`timescale 1ns/10ps
module pin_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_srst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         meta   <= '0;
         o_sync <= '0;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule // pin_sync

// *** rtl/scan_tap.sv ***
// boundary-scan tap controller, instruction register and test data registers
//
// Overview of operation
// [R1] instruction register is two bits wide
// [R2] instruction bits shift in from tdi only in the shift-ir state
// [R3] current instruction selects the data register placed between tdi and tdo
// [R4] only two data registers exist: boundary-scan and bypass
// [R5] bypass path is a single stage, one-bit delay
// [R6] boundary register has 84 cells; cell 0 leaves tdo first
// [R7] enable cells are active high; 1 enables the pin group
// [R8] all-zero boundary register tristates every output under scan control
// [R9] cells 0-23 frame groups b,a; 24-31 outbound streams, enable cell 32
// [R10] cells 33-40 inbound streams, enable cell 41
// [R11] cells 47-51 local frame, clocks, control stream; cell 52 output-only enable
// [R12] cells 63-70 data bus bits 7..0, enable cell 71
// [R13] cells 76-83 capture rd, wr, cs, ale, address, dma acknowledge
// [R14] tms and tdi sampled on rising tck; undriven reads as 1
// [R15] tdo changes on falling tck, high impedance when not shifting
// [R16] 00 extest, 01 sample/preload, 10 bypass with pins under scan control
// [R17] test-logic reset loads the functional bypass instruction
// [R18] standard sixteen-state tap; code 11 acts as functional bypass
`timescale 1ns/10ps
module scan_tap #(
   parameter int unsigned CELLS = scan_tap_pkg::BSR_CELLS
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_srst,
   input  wire logic             i_tck,
   input  wire logic             i_tms,
   input  wire logic             i_tdi,
   output logic                  o_tdo,
   output logic                  o_tdo_oe,
   input  wire logic [CELLS-1:0] i_core_val,
   input  wire logic [CELLS-1:0] i_pin_val,
   output logic      [CELLS-1:0] o_pin_drive,
   output logic                  o_scan_ctrl,
   output logic                  o_oe_outbound,
   output logic                  o_oe_inbound,
   output logic                  o_oe_clock_in,
   output logic                  o_oe_output_only,
   output logic                  o_oe_data,
   output logic [scan_tap_pkg::IR_WIDTH-1:0] o_instr
);
   // ----------------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------------
   logic [2:0]       tap_sync;
   logic [CELLS-1:0] pin_sync_val;
   logic             tck_prev;
   logic             tck_rise;
   logic             tck_fall;
   logic             tms_s;
   logic             tdi_s;

   // pad pull-ups turn an undriven tms or tdi into a 1 before this point
   pin_sync #(.WIDTH(3)) u_tap_sync ( // R14
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_async   ({i_tck, i_tms, i_tdi}),
      .o_sync    (tap_sync)
   );

   pin_sync #(.WIDTH(CELLS)) u_pin_sync (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_async   (i_pin_val),
      .o_sync    (pin_sync_val)
   );

   assign tms_s = tap_sync[1];
   assign tdi_s = tap_sync[0];

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         tck_prev <= 1'b0;
      end else begin
         tck_prev <= tap_sync[2];
      end
   end

   // tms and tdi are synchronised alongside tck, so they are stable at the edge
   assign tck_rise = tap_sync[2] & ~tck_prev; // R14
   assign tck_fall = ~tap_sync[2] & tck_prev; // R15

   // ----------------------------------------------------------------------
   // tap controller
   // ----------------------------------------------------------------------
   scan_tap_pkg::tap_state_e state;
   scan_tap_pkg::tap_state_e next_state;

   always_comb begin
      next_state = state;
      case (state) // R18
         scan_tap_pkg::ST_TEST_LOGIC_RESET: next_state = tms_s ?
            scan_tap_pkg::ST_TEST_LOGIC_RESET : scan_tap_pkg::ST_RUN_IDLE;
         scan_tap_pkg::ST_RUN_IDLE: next_state = tms_s ?
            scan_tap_pkg::ST_SELECT_DR : scan_tap_pkg::ST_RUN_IDLE;
         scan_tap_pkg::ST_SELECT_DR: next_state = tms_s ?
            scan_tap_pkg::ST_SELECT_IR : scan_tap_pkg::ST_CAPTURE_DR;
         scan_tap_pkg::ST_CAPTURE_DR: next_state = tms_s ?
            scan_tap_pkg::ST_EXIT1_DR : scan_tap_pkg::ST_SHIFT_DR;
         scan_tap_pkg::ST_SHIFT_DR: next_state = tms_s ?
            scan_tap_pkg::ST_EXIT1_DR : scan_tap_pkg::ST_SHIFT_DR;
         scan_tap_pkg::ST_EXIT1_DR: next_state = tms_s ?
            scan_tap_pkg::ST_UPDATE_DR : scan_tap_pkg::ST_PAUSE_DR;
         scan_tap_pkg::ST_PAUSE_DR: next_state = tms_s ?
            scan_tap_pkg::ST_EXIT2_DR : scan_tap_pkg::ST_PAUSE_DR;
         scan_tap_pkg::ST_EXIT2_DR: next_state = tms_s ?
            scan_tap_pkg::ST_UPDATE_DR : scan_tap_pkg::ST_SHIFT_DR;
         scan_tap_pkg::ST_UPDATE_DR: next_state = tms_s ?
            scan_tap_pkg::ST_SELECT_DR : scan_tap_pkg::ST_RUN_IDLE;
         scan_tap_pkg::ST_SELECT_IR: next_state = tms_s ?
            scan_tap_pkg::ST_TEST_LOGIC_RESET : scan_tap_pkg::ST_CAPTURE_IR;
         scan_tap_pkg::ST_CAPTURE_IR: next_state = tms_s ?
            scan_tap_pkg::ST_EXIT1_IR : scan_tap_pkg::ST_SHIFT_IR;
         scan_tap_pkg::ST_SHIFT_IR: next_state = tms_s ?
            scan_tap_pkg::ST_EXIT1_IR : scan_tap_pkg::ST_SHIFT_IR;
         scan_tap_pkg::ST_EXIT1_IR: next_state = tms_s ?
            scan_tap_pkg::ST_UPDATE_IR : scan_tap_pkg::ST_PAUSE_IR;
         scan_tap_pkg::ST_PAUSE_IR: next_state = tms_s ?
            scan_tap_pkg::ST_EXIT2_IR : scan_tap_pkg::ST_PAUSE_IR;
         scan_tap_pkg::ST_EXIT2_IR: next_state = tms_s ?
            scan_tap_pkg::ST_UPDATE_IR : scan_tap_pkg::ST_SHIFT_IR;
         scan_tap_pkg::ST_UPDATE_IR: next_state = tms_s ?
            scan_tap_pkg::ST_SELECT_DR : scan_tap_pkg::ST_RUN_IDLE;
         default: next_state = scan_tap_pkg::ST_TEST_LOGIC_RESET;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state <= scan_tap_pkg::ST_TEST_LOGIC_RESET;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------------
   logic [scan_tap_pkg::IR_WIDTH-1:0] ir_shift; // R1
   logic [scan_tap_pkg::IR_WIDTH-1:0] instr;
   logic                              sel_bsr;
   logic                              pins_scan;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         ir_shift <= scan_tap_pkg::IR_CAPTURE_VALUE;
      end else if (tck_rise) begin
         if (state == scan_tap_pkg::ST_CAPTURE_IR) begin
            ir_shift <= scan_tap_pkg::IR_CAPTURE_VALUE;
         end else if (state == scan_tap_pkg::ST_SHIFT_IR) begin
            ir_shift <= {tdi_s, ir_shift[scan_tap_pkg::IR_WIDTH-1:1]}; // R2
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         instr <= scan_tap_pkg::bypass_functional; // R17
      end else if (tck_rise) begin
         if (state == scan_tap_pkg::ST_TEST_LOGIC_RESET) begin
            instr <= scan_tap_pkg::bypass_functional; // R17
         end else if (state == scan_tap_pkg::ST_UPDATE_IR) begin
            instr <= ir_shift;
         end
      end
   end

   // code 11 falls into the functional bypass by not matching any test code
   assign sel_bsr   = (instr == scan_tap_pkg::INSTR_EXTEST) ||
                      (instr == scan_tap_pkg::INSTR_SAMPLE); // R3 R16 R18
   assign pins_scan = (instr == scan_tap_pkg::INSTR_EXTEST) ||
                      (instr == scan_tap_pkg::INSTR_BYPASS_TEST); // R16

   // ----------------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------------
   logic [CELLS-1:0] bsr_shift; // R4 R6
   logic [CELLS-1:0] bsr_update;
   logic             bypass_bit; // R4 R5

   // capture takes pin levels for every cell, so the cell map fixes the order
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         bsr_shift <= '0;
      end else if (tck_rise && sel_bsr) begin
         if (state == scan_tap_pkg::ST_CAPTURE_DR) begin
            bsr_shift <= pin_sync_val; // R9 R10 R11 R12 R13
         end else if (state == scan_tap_pkg::ST_SHIFT_DR) begin
            bsr_shift <= {tdi_s, bsr_shift[CELLS-1:1]}; // R6
         end
      end
   end

   // zero at reset keeps every pin group tristated if scan control is taken
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         bsr_update <= '0;
      end else if (tck_rise && sel_bsr && state == scan_tap_pkg::ST_UPDATE_DR) begin
         bsr_update <= bsr_shift;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         bypass_bit <= 1'b0;
      end else if (tck_rise && !sel_bsr) begin
         if (state == scan_tap_pkg::ST_CAPTURE_DR) begin
            bypass_bit <= 1'b0;
         end else if (state == scan_tap_pkg::ST_SHIFT_DR) begin
            bypass_bit <= tdi_s; // R5
         end
      end
   end

   // ----------------------------------------------------------------------
   // test data out
   // ----------------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         if (state == scan_tap_pkg::ST_SHIFT_IR) begin
            o_tdo    <= ir_shift[0];
            o_tdo_oe <= 1'b1;
         end else if (state == scan_tap_pkg::ST_SHIFT_DR) begin
            o_tdo    <= sel_bsr ? bsr_shift[0] : bypass_bit; // R3 R6
            o_tdo_oe <= 1'b1;
         end else begin
            o_tdo_oe <= 1'b0; // R15
         end
      end
   end

   // ----------------------------------------------------------------------
   // pin control
   // ----------------------------------------------------------------------
   logic [CELLS-1:0] drive_src;

   assign drive_src = pins_scan ? bsr_update : i_core_val; // R16

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_pin_drive      <= '0;
         o_scan_ctrl      <= 1'b0;
         o_oe_outbound    <= 1'b0;
         o_oe_inbound     <= 1'b0;
         o_oe_clock_in    <= 1'b0;
         o_oe_output_only <= 1'b0;
         o_oe_data        <= 1'b0;
         o_instr          <= scan_tap_pkg::bypass_functional;
      end else begin
         o_pin_drive      <= drive_src;
         o_scan_ctrl      <= pins_scan;
         o_oe_outbound    <= drive_src[scan_tap_pkg::CELL_OE_OUTBOUND]; // R7 R8 R9
         o_oe_inbound     <= drive_src[scan_tap_pkg::CELL_OE_INBOUND]; // R7 R8 R10
         o_oe_clock_in    <= drive_src[scan_tap_pkg::CELL_OE_CLOCK_IN]; // R7 R8
         o_oe_output_only <= drive_src[scan_tap_pkg::CELL_OE_OUTPUT_ONLY]; // R7 R8 R11
         o_oe_data        <= drive_src[scan_tap_pkg::CELL_OE_DATA]; // R7 R8 R12
         o_instr          <= instr;
      end
   end
endmodule // scan_tap

// *** test/scan_tap_props.sv ***
// concurrent checks on the scan tap ports
`timescale 1ns/10ps
module scan_tap_props #(
   parameter int unsigned CELLS = 84
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_srst,
   input  wire logic             i_tck,
   input  wire logic             i_tms,
   input  wire logic             i_tdi,
   input  wire logic             o_tdo,
   input  wire logic             o_tdo_oe,
   input  wire logic [CELLS-1:0] i_core_val,
   input  wire logic [CELLS-1:0] i_pin_val,
   input  wire logic [CELLS-1:0] o_pin_drive,
   input  wire logic             o_scan_ctrl,
   input  wire logic             o_oe_outbound,
   input  wire logic             o_oe_inbound,
   input  wire logic             o_oe_clock_in,
   input  wire logic             o_oe_output_only,
   input  wire logic             o_oe_data,
   input  wire logic [1:0]       o_instr
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   // ----------------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------------
   sequence s_released; $past(i_srst) ##0 !i_srst; endsequence
   sequence s_scan_code; (o_instr == 2'h0 || o_instr == 2'h2) [*2]; endsequence
   sequence s_free_code; (o_instr == 2'h1 || o_instr == 2'h3) [*2]; endsequence
   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   a_reset_instr: assert property (s_released |-> o_instr == 2'h3 && !o_tdo_oe)
      else $error("instruction or tdo enable wrong after reset");
   a_scan_ctrl_on: assert property (s_scan_code |-> o_scan_ctrl)
      else $error("scan control missing for extest or bypass test");
   a_scan_ctrl_off: assert property (s_free_code |-> !o_scan_ctrl)
      else $error("scan control taken in a functional instruction");
   a_drive_functional: assert property ((!o_scan_ctrl) [*2] |-> o_pin_drive == $past(i_core_val))
      else $error("pins do not follow core outside scan control");
   // enables and pin values leave the same register stage, so they agree in every cycle
   a_oe_outbound: assert property (o_oe_outbound == o_pin_drive[32])
      else $error("outbound enable not cell 32");
   a_oe_inbound: assert property (o_oe_inbound == o_pin_drive[41])
      else $error("inbound enable not cell 41");
   a_oe_output_only: assert property (o_oe_output_only == o_pin_drive[52])
      else $error("output-only enable not cell 52");
   a_oe_data: assert property (o_oe_data == o_pin_drive[71])
      else $error("data bus enable not cell 71");
   // tck low phase is longer than the detect latency, so a change must land while tck is low
   a_tdo_on_fall: assert property ($changed(o_tdo) |-> !i_tck)
      else $error("tdo changed in tck high phase");
   a_tdo_oe_timing: assert property ($changed(o_tdo_oe) |-> !i_tck)
      else $error("tdo enable changed in tck high phase");
endmodule // scan_tap_props

bind scan_tap scan_tap_props #(.CELLS(CELLS)) u_props (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
   .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
   .i_core_val(i_core_val), .i_pin_val(i_pin_val), .o_pin_drive(o_pin_drive),
   .o_scan_ctrl(o_scan_ctrl), .o_oe_outbound(o_oe_outbound), .o_oe_inbound(o_oe_inbound),
   .o_oe_clock_in(o_oe_clock_in), .o_oe_output_only(o_oe_output_only),
   .o_oe_data(o_oe_data), .o_instr(o_instr));

// *** test/scan_tap_tb.sv ***
// self-checking testbench for the scan tap
`timescale 1ns/10ps
module scan_tap_tb;
   localparam int unsigned N = 84;
   typedef struct {logic [1:0] code; logic ctrl;} row_s;
   row_s         rows [4] = '{'{2'h0, 1'b1}, '{2'h1, 1'b0}, '{2'h2, 1'b1}, '{2'h3, 1'b0}};
   int           n_errors = 0;
   int           cmp_count = 0;
   logic         i_ref_clk, i_srst, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_scan_ctrl;
   logic         oe_out, oe_in, oe_clk, oe_only, oe_data;
   logic [1:0]   o_instr, cap;
   logic [N-1:0] core = 84'hFEDCBA9876543210FEDCB;
   logic [N-1:0] pins = 84'h123456789ABCDEF012345;
   logic [N-1:0] pre  = 84'h5A5A5A5A5A5A5A5A5A5A5;
   logic [N-1:0] o_pin_drive, dout;

   scan_tap #(.CELLS(N)) u_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_tck(i_tck),
      .i_tms(i_tms), .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_core_val(core),
      .i_pin_val(pins), .o_pin_drive(o_pin_drive), .o_scan_ctrl(o_scan_ctrl),
      .o_oe_outbound(oe_out), .o_oe_inbound(oe_in), .o_oe_clock_in(oe_clk),
      .o_oe_output_only(oe_only), .o_oe_data(oe_data), .o_instr(o_instr));
   // a released tdo shows the inverse, so a read outside a shift is caught
   scan_tester u_tester (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
      .i_tdo(o_tdo_oe ? o_tdo : ~o_tdo));

   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task automatic chk(input logic [N-1:0] seen, input logic [N-1:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask
   task automatic settle();
      repeat (10) @(negedge i_ref_clk);
      // 1 ns off the edge keeps every later tck edge clear of a reference edge
      #1;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      i_srst = 1'b1;
      repeat (5) @(negedge i_ref_clk);
      i_srst = 1'b0;
      repeat (3) @(negedge i_ref_clk);
      chk(o_instr, 2'h3, "instruction after reset");
      chk(o_tdo_oe, 1'b0, "tdo driven after reset");
      #1;
      u_tester.reset_tap();
      foreach (rows[i]) begin
         u_tester.load_ir(rows[i].code, cap);
         settle();
         chk(cap, 2'h1, "instruction capture");
         chk(o_instr, rows[i].code, "instruction load");
         chk(o_scan_ctrl, rows[i].ctrl, "scan control");
         chk(o_pin_drive, rows[i].ctrl ? '0 : core, "pin source");
         if (rows[i].code[1]) begin
            u_tester.scan_dr(84'hD, 5, dout);
            chk(dout[4:0], 5'h1A, "bypass delay");
         end
         $display("row %0d done", i);
      end
      // sample/preload: pins captured, preload lands in the latch only
      u_tester.load_ir(2'h1, cap);
      u_tester.scan_dr(pre, N, dout);
      settle();
      chk(dout, pins, "capture order");
      chk(o_pin_drive, core, "pins follow core in sample");
      $display("sample test done");
      u_tester.load_ir(2'h0, cap);
      settle();
      chk(o_pin_drive, pre, "extest drives preload");
      chk({oe_out, oe_in, oe_clk, oe_only, oe_data},
          {pre[32], pre[41], pre[46], pre[52], pre[71]}, "enables");
      u_tester.scan_dr('0, N, dout);
      settle();
      chk(dout, pins, "extest capture path");
      chk(o_pin_drive, '0, "all zero pins");
      chk({oe_out, oe_in, oe_clk, oe_only, oe_data}, 5'h0, "all zero enables");
      chk(o_tdo_oe, 1'b0, "tdo released when idle");
      $display("extest test done");
      u_tester.reset_tap();
      settle();
      chk(o_instr, 2'h3, "tap reset instruction");
      chk(o_pin_drive, core, "pins follow core after tap reset");
      $display("tap reset test done");
      print_verdict();
   end
   // the run needs about 35 us of tck traffic; a hang past 200 us is a failure
   initial begin
      #200us;
      n_errors++;
      print_verdict();
   end
endmodule // scan_tap_tb

// *** test/scan_tester.sv ***
// model of the external tester that drives the tap pins
`timescale 1ns/10ps
module scan_tester (
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   input  wire logic i_tdo
);
   // tck rests low between operations; tdi idles high like a pulled-up pin, tms starts high but rests low after each task
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   // pins move only in the low phase so each rise samples them clean
   task automatic bit_io(input logic tms, input logic tdi, output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      #62.5;
      tdo = i_tdo;
      o_tck = 1'b1;
      #62.5;
      // tms and tdi hold until the next bit sets them, so no pin is written twice at once
      o_tck = 1'b0;
   endtask
   task automatic reset_tap();
      logic d;
      repeat (5) bit_io(1'b1, 1'b1, d);
      bit_io(1'b0, 1'b1, d);
   endtask
   task automatic load_ir(input logic [1:0] code, output logic [1:0] cap);
      logic d;
      bit_io(1'b1, 1'b1, d);
      bit_io(1'b1, 1'b1, d);
      bit_io(1'b0, 1'b1, d);
      bit_io(1'b0, 1'b1, d);
      bit_io(1'b0, code[0], cap[0]);
      bit_io(1'b1, code[1], cap[1]);
      bit_io(1'b1, 1'b1, d);
      bit_io(1'b0, 1'b1, d);
   endtask
   task automatic scan_dr(input logic [83:0] din, input int n, output logic [83:0] dout);
      logic d;
      dout = '0;
      bit_io(1'b1, 1'b1, d);
      bit_io(1'b0, 1'b1, d);
      bit_io(1'b0, 1'b1, d);
      for (int i = 0; i < n; i++) bit_io(i == n - 1, din[i], dout[i]);
      bit_io(1'b1, 1'b1, d);
      bit_io(1'b0, 1'b1, d);
   endtask
endmodule // scan_tester
